// ==== hw/gtm_defines.svh ====
// Register offsets, field positions and reset values of the gated timer
// Assumes a 32-bit APB slave with word-aligned registers
`ifndef GTM_DEFINES_SVH
`define GTM_DEFINES_SVH

`define GTM_OFF_CTRL 12'h000
`define GTM_OFF_CNTL 12'h004
`define GTM_OFF_CNTH 12'h008
`define GTM_OFF_GATE 12'h00C
`define GTM_OFF_STAT 12'h010
`define GTM_OFF_MASK 12'h014
`define GTM_OFF_OSC 12'h018

`define GTM_CTRL_ON 0
`define GTM_CTRL_SYNCDIS 2
`define GTM_CTRL_OSCEN 3
`define GTM_CTRL_PS_LO 4
`define GTM_CTRL_SRC_LO 6
`define GTM_GATE_SS_LO 0
`define GTM_GATE_POL 6
`define GTM_GATE_EN 7
`define GTM_ST_OVF 0

`define GTM_CTRL_RST 8'h00
`define GTM_GATE_RST 8'h00
`define GTM_SLEEP_OK_BIT 1
`define GTM_OSC_READY_BIT 7

`define GTM_XTAL_KHZ_X1000 32768
`define GTM_OSC_START_US 1000
`define GTM_CLK_MHZ 100
`define GTM_OSC_START_CYC (`GTM_OSC_START_US * `GTM_CLK_MHZ)

`endif

// ==== hw/gtm_pkg.sv ====
// Types of the gated timer
// Assumes gtm_defines.svh is compiled alongside
package gtm_pkg;
  typedef enum logic [1:0] {
    GTM_SRC_SYS,
    GTM_SRC_SYS4,
    GTM_SRC_PIN,
    GTM_SRC_XTAL
  } gtm_clksrc_e;
  typedef enum logic [1:0] {
    GTM_GS_PIN,
    GTM_GS_COMP,
    GTM_GS_AUX2,
    GTM_GS_AUX3
  } gtm_gsrc_e;
endpackage

// ==== hw/gtm_timer.sv ====
// Gated 16-bit timer with prescaler, crystal oscillator control and APB slave
// Assumes mclk 100 MHz; pins and oscillator ticks are asynchronous levels
//
// Notes on behaviour
// [RULE1] Input clock divided by 1, 2, 4 or 8 per prescale_select field.
// [RULE2] Prescale counter hidden; cleared by any write to a count byte.
// [RULE3] Oscillator enable drives crystal oscillator; it keeps running in Sleep.
// [RULE4] Software waits oscillator start-up before counting from the crystal.
// [RULE5] Sync disable skips pin synchroniser stage; counting is unsynchronised. Here both settings still read the edge after two flops.
// [RULE6] Async external counting continues in Sleep; overflow can wake.
// [RULE7] Mode switches may lose or add one increment.
// [RULE8] Count byte reads always return a valid value.
// [RULE9] Count read as two bytes, no coherent latch.
// [RULE10] Software stops counter before writing count bytes.
// [RULE11] Gate enable bit selects gated counting, else free counting.
// [RULE12] Gated: increments on source rising edge while gate active.
// [RULE13] Gate active when gate level equals gate polarity bit.
// [RULE14] Four gate sources via two-bit select; 00 is gate pin.
// [RULE15] Gate source 01 is companion 8-bit timer wrap.
// [RULE16] Oscillator ready reads readiness if enabled, else reads one.
// [RULE17] Counter wraps to zero and sets overflow flag every wrap.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "gtm_defines.svh"

module gtm_timer #(
  parameter int OSC_START_CYC = `GTM_OSC_START_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counterClockPin,
  input wire logic crystalInPin,
  output logic crystalOscEnable,
  input wire logic gateInput,
  input wire logic companionWrap,
  input wire logic gateAux2,
  input wire logic gateAux3,
  input wire logic sleepMode,
  output logic irq
);

  logic [7:0] ctrl_ff;
  logic [7:0] gateCtrl_ff;
  logic [15:0] count_ff;
  logic [2:0] presc_ff;
  logic [1:0] div4_ff;
  logic [2:0] pinSync_ff;
  logic [2:0] xtalSync_ff;
  logic [1:0] gateSync_ff;
  logic [1:0] compSync_ff;
  logic [1:0] aux2Sync_ff;
  logic [1:0] aux3Sync_ff;
  logic [31:0] oscCnt_ff;
  logic oscReady_ff;
  logic status_ff;
  logic mask_ff;
  logic compSeen_ff;

  logic wrEn;
  logic rdEn;
  logic countWr;
  logic srcTick;
  logic gateLevel;
  logic gateOk;
  logic presTick;
  logic incEn;
  logic ovf;
  logic [7:0] nxt_presMask;
  gtm_pkg::gtm_clksrc_e clkSrc;
  gtm_pkg::gtm_gsrc_e gateSrc;

  function automatic logic [2:0] presMaskOf(input logic [1:0] sel);
    presMaskOf = 3'(({1'b0, 2'h0} + 3'h1 << sel) - 3'h1);
  endfunction

  function automatic logic rise(input logic [2:0] s, input logic useOlder);
    rise = useOlder ? (s[2] & ~s[1]) : (s[1] & ~s[2]);
  endfunction

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign countWr = wrEn && (paddr == `GTM_OFF_CNTL || paddr == `GTM_OFF_CNTH);
  assign clkSrc = gtm_pkg::gtm_clksrc_e'(ctrl_ff[`GTM_CTRL_SRC_LO +: 2]);
  assign gateSrc = gtm_pkg::gtm_gsrc_e'(gateCtrl_ff[`GTM_GATE_SS_LO +: 2]);
  assign nxt_presMask = {5'h00, presMaskOf(ctrl_ff[`GTM_CTRL_PS_LO +: 2])};

  // Input synchronisers; only second stage onward is read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinSync_ff <= 3'h0;
      xtalSync_ff <= 3'h0;
      gateSync_ff <= 2'h0;
      compSync_ff <= 2'h0;
      aux2Sync_ff <= 2'h0;
      aux3Sync_ff <= 2'h0;
    end else begin
      pinSync_ff <= {pinSync_ff[1:0], counterClockPin};
      xtalSync_ff <= {xtalSync_ff[1:0], crystalInPin};
      gateSync_ff <= {gateSync_ff[0], gateInput};
      compSync_ff <= {compSync_ff[0], companionWrap};
      aux2Sync_ff <= {aux2Sync_ff[0], gateAux2};
      aux3Sync_ff <= {aux3Sync_ff[0], gateAux3};
    end
  end

  // Rising edge seen after two flops in both modes; one clock leaves no bypass
  always_comb begin
    unique case (clkSrc)
      gtm_pkg::GTM_SRC_SYS: srcTick = 1'b1;
      gtm_pkg::GTM_SRC_SYS4: srcTick = (div4_ff == 2'h3);
      gtm_pkg::GTM_SRC_PIN: begin
        srcTick = ctrl_ff[`GTM_CTRL_SYNCDIS] ? rise({pinSync_ff[1], pinSync_ff[2], 1'b0}, 1'b1)
                                             : rise(pinSync_ff, 1'b0); // RULE5 RULE7 RULE12
      end
      gtm_pkg::GTM_SRC_XTAL: begin
        srcTick = ctrl_ff[`GTM_CTRL_SYNCDIS] ? rise({xtalSync_ff[1], xtalSync_ff[2], 1'b0}, 1'b1)
                                              : rise(xtalSync_ff, 1'b0); // RULE5 RULE7
      end
    endcase
  end

  // Gate source select and polarity
  always_comb begin
    unique case (gateSrc)
      gtm_pkg::GTM_GS_PIN: gateLevel = gateSync_ff[1]; // RULE14
      gtm_pkg::GTM_GS_COMP: gateLevel = compSeen_ff; // RULE15
      gtm_pkg::GTM_GS_AUX2: gateLevel = aux2Sync_ff[1];
      gtm_pkg::GTM_GS_AUX3: gateLevel = aux3Sync_ff[1];
    endcase
  end

  assign gateOk = !gateCtrl_ff[`GTM_GATE_EN] ||
                  (gateLevel == gateCtrl_ff[`GTM_GATE_POL]); // RULE11 RULE13
  // Sleep stops system-clock sources but not pin or crystal counting
  assign presTick = ctrl_ff[`GTM_CTRL_ON] && srcTick && gateOk && !countWr &&
                    !(sleepMode && (clkSrc == gtm_pkg::GTM_SRC_SYS ||
                                    clkSrc == gtm_pkg::GTM_SRC_SYS4)); // RULE6 RULE12
  assign incEn = presTick && ((presc_ff & nxt_presMask[2:0]) == nxt_presMask[2:0]);
  assign ovf = incEn && (count_ff == 16'hFFFF);

  // Companion wrap level registered once more after its synchroniser, following it every cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      compSeen_ff <= 1'b0;
    end else begin
      compSeen_ff <= compSync_ff[1];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div4_ff <= 2'h0;
    end else begin
      div4_ff <= 2'(div4_ff + 2'h1);
    end
  end

  // Prescaler
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      presc_ff <= 3'h0;
    end else if (countWr) begin
      presc_ff <= 3'h0; // RULE2
    end else if (incEn) begin
      presc_ff <= 3'h0; // RULE1
    end else if (presTick) begin
      presc_ff <= 3'(presc_ff + 3'h1); // RULE1
    end
  end

  // Counter; a byte write wins over an increment in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
    end else if (wrEn && paddr == `GTM_OFF_CNTL) begin
      count_ff[7:0] <= pwdata[7:0];
    end else if (wrEn && paddr == `GTM_OFF_CNTH) begin
      count_ff[15:8] <= pwdata[7:0];
    end else if (incEn) begin
      count_ff <= 16'(count_ff + 16'h0001); // RULE17
    end
  end

  // Control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `GTM_CTRL_RST;
      gateCtrl_ff <= `GTM_GATE_RST;
      mask_ff <= 1'b0;
    end else if (wrEn) begin
      if (paddr == `GTM_OFF_CTRL) begin
        ctrl_ff <= pwdata[7:0];
      end
      if (paddr == `GTM_OFF_GATE) begin
        gateCtrl_ff <= pwdata[7:0];
      end
      if (paddr == `GTM_OFF_MASK) begin
        mask_ff <= pwdata[`GTM_ST_OVF];
      end
    end
  end

  // Oscillator enable and start-up readiness; not gated by sleep
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crystalOscEnable <= 1'b0;
      oscCnt_ff <= 32'h0000_0000;
      oscReady_ff <= 1'b0;
    end else begin
      crystalOscEnable <= ctrl_ff[`GTM_CTRL_OSCEN]; // RULE3
      if (!ctrl_ff[`GTM_CTRL_OSCEN]) begin
        oscCnt_ff <= 32'h0000_0000;
        oscReady_ff <= 1'b0;
      end else if (oscCnt_ff < 32'(OSC_START_CYC)) begin
        oscCnt_ff <= 32'(oscCnt_ff + 32'h1);
      end else begin
        oscReady_ff <= 1'b1;
      end
    end
  end

  // Overflow status, set wins over write-one clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_ff <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (ovf) begin
        status_ff <= 1'b1; // RULE17
      end else if (wrEn && paddr == `GTM_OFF_STAT && pwdata[`GTM_ST_OVF]) begin
        status_ff <= 1'b0;
      end
      irq <= (status_ff || ovf) && mask_ff; // RULE6
    end
  end

  // APB read path, one wait-free access phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          `GTM_OFF_CTRL: prdata <= {24'h000000, ctrl_ff};
          `GTM_OFF_CNTL: prdata <= {24'h000000, count_ff[7:0]}; // RULE8 RULE9
          `GTM_OFF_CNTH: prdata <= {24'h000000, count_ff[15:8]}; // RULE8 RULE9
          `GTM_OFF_GATE: prdata <= {24'h000000, gateCtrl_ff};
          `GTM_OFF_STAT: prdata <= {31'h0, status_ff};
          `GTM_OFF_MASK: prdata <= {31'h0, mask_ff};
          `GTM_OFF_OSC: prdata <= {24'h000000,
                                   !ctrl_ff[`GTM_CTRL_OSCEN] || oscReady_ff, 7'h00}; // RULE16
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Assertions
  a_prescale_clear: assert property (@(posedge mclk) disable iff (rst)
    countWr |=> presc_ff == 3'h0) else $error("prescaler not cleared"); // RULE2
  a_free_count: assert property (@(posedge mclk) disable iff (rst)
    (ctrl_ff[`GTM_CTRL_ON] && !gateCtrl_ff[`GTM_GATE_EN] && clkSrc == gtm_pkg::GTM_SRC_SYS &&
    ctrl_ff[`GTM_CTRL_PS_LO +: 2] == 2'h0 && !sleepMode && !wrEn)
    |=> count_ff == 16'($past(count_ff) + 16'h0001)) else $error("free count stalled"); // RULE11
  a_gate_hold: assert property (@(posedge mclk) disable iff (rst)
    (gateCtrl_ff[`GTM_GATE_EN] && gateLevel != gateCtrl_ff[`GTM_GATE_POL] && !wrEn)
    |=> count_ff == $past(count_ff)) else $error("count moved with gate closed"); // RULE12 RULE13
  a_wrap_flag: assert property (@(posedge mclk) disable iff (rst)
    ovf |=> status_ff && count_ff == 16'h0000) else $error("wrap missed"); // RULE17
  a_irq_level: assert property (@(posedge mclk) disable iff (rst)
    (status_ff && mask_ff) |=> irq) else $error("irq not raised"); // RULE6
  a_osc_ready: assert property (@(posedge mclk) disable iff (rst)
    !ctrl_ff[`GTM_CTRL_OSCEN] |=> !oscReady_ff) else $error("ready held"); // RULE16
  a_osc_enable: assert property (@(posedge mclk) disable iff (rst)
    ctrl_ff[`GTM_CTRL_OSCEN] |=> crystalOscEnable) else $error("osc off"); // RULE3
  a_div_one: assert property (@(posedge mclk) disable iff (rst)
    (ctrl_ff[`GTM_CTRL_PS_LO +: 2] == 2'h0 && presTick) |-> incEn)
    else $error("div1 skipped"); // RULE1
  a_read_low: assert property (@(posedge mclk) disable iff (rst)
    (psel && !penable && !pwrite && paddr == `GTM_OFF_CNTL) |=>
    prdata[7:0] == $past(count_ff[7:0])) else $error("bad low read"); // RULE8

endmodule
`default_nettype wire

// ==== dv/gtm_far_side.sv ====
// Far-side model: external count clock pin and crystal
// Assumes the timer treats both pins as asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module gtm_far_side #(
  parameter int XTAL_HALF_NS = 15259
) (
  input wire logic crystalOscEnable,
  output logic crystalInPin,
  output logic counterClockPin
);
  initial begin
    crystalInPin = 1'b0;
    counterClockPin = 1'b0;
  end
  // Crystal swings only while enabled, Sleep or not
  always begin
    wait (crystalOscEnable === 1'b1);
    #XTAL_HALF_NS crystalInPin = ~crystalInPin;
  end
  // Pin pulses unrelated in phase to mclk
  task automatic pulsePin(input int n);
    repeat (n) begin
      #27 counterClockPin = 1'b1;
      #33 counterClockPin = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/gated_16bit_timer_test.sv ====
// Self-checking bench of the gated timer over APB
// Assumes gtm_defines.svh on the include path and the far-side model
`timescale 1ns/100ps
`default_nettype none
`include "gtm_defines.svh"
module gated_16bit_timer_test;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq, slvErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic counterClockPin, crystalInPin, crystalOscEnable, gateInput;
  logic companionWrap, gateAux2, gateAux3, sleepMode;
  int failCount, checkCount;
  gtm_timer #(.OSC_START_CYC(20)) i_gtm_timer (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counterClockPin(counterClockPin), .crystalInPin(crystalInPin),
    .crystalOscEnable(crystalOscEnable), .gateInput(gateInput),
    .companionWrap(companionWrap), .gateAux2(gateAux2), .gateAux3(gateAux3),
    .sleepMode(sleepMode), .irq(irq));
  gtm_far_side #(.XTAL_HALF_NS(45)) i_gtm_far_side (.crystalOscEnable(crystalOscEnable),
    .crystalInPin(crystalInPin), .counterClockPin(counterClockPin));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checkCount++;
    if (^got === 1'bx || got < lo || got > hi) begin
      $display("unexpected at %0t: got %0h want %0h..%0h", $time, got, lo, hi);
      failCount++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Stop, clear, configure, count for a while, stop, read both bytes
  task automatic run(input logic [7:0] ctl, input logic [7:0] gt, input int cyc,
                     input int np, output logic [15:0] cnt);
    apb(1'b1, `GTM_OFF_CTRL, {24'h0, ctl & 8'hFE});
    apb(1'b1, `GTM_OFF_CNTL, 32'h0);
    apb(1'b1, `GTM_OFF_CNTH, 32'h0);
    apb(1'b1, `GTM_OFF_GATE, {24'h0, gt});
    apb(1'b1, `GTM_OFF_CTRL, {24'h0, ctl});
    i_gtm_far_side.pulsePin(np);
    repeat (cyc) @(posedge mclk);
    apb(1'b1, `GTM_OFF_CTRL, {24'h0, ctl & 8'hFE});
    apb(1'b0, `GTM_OFF_CNTL, 32'h0);
    cnt[7:0] = rd[7:0];
    apb(1'b0, `GTM_OFF_CNTH, 32'h0);
    cnt[15:8] = rd[7:0];
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    $display("unexpected at %0t: watchdog expired", $time);
    failCount++;
    testDone();
  end
  initial begin
    logic [15:0] c;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {gateInput, companionWrap, gateAux2, gateAux3, sleepMode} = 5'h00;
    failCount = 0;
    checkCount = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // Reset values and an unmapped slot
    apb(1'b0, `GTM_OFF_CTRL, 32'h0);
    chk(rd, `GTM_CTRL_RST, `GTM_CTRL_RST);
    apb(1'b0, `GTM_OFF_GATE, 32'h0);
    chk(rd, `GTM_GATE_RST, `GTM_GATE_RST);
    apb(1'b0, `GTM_OFF_OSC, 32'h0);
    chk(rd[7], 1, 1);
    apb(1'b0, 12'h020, 32'h0);
    chk(slvErr, 1, 1);
    chk(rd, 0, 0);
    // Prescale ratios on the system clock
    for (int p = 0; p < 4; p++) begin
      run({2'b00, p[1:0], 4'h1}, 8'h00, 80, 0, c);
      chk(c, 80 >> p, (84 >> p) + 1);
    end
    // System clock divided by four
    run(8'h41, 8'h00, 80, 0, c);
    chk(c, 20, 21);
    // Every gate source at level low, both polarities
    for (int s = 0; s < 4; s++) begin
      for (int q = 0; q < 2; q++) begin
        run(8'h01, {1'b1, q[0], 4'h0, s[1:0]}, 40, 0, c);
        chk(c, q ? 0 : 40, q ? 0 : 45);
      end
    end
    gateInput <= 1'b1;
    run(8'h01, 8'hC0, 40, 0, c);
    chk(c, 40, 45);
    gateInput <= 1'b0;
    companionWrap <= 1'b1;
    run(8'h01, 8'hC1, 40, 0, c);
    chk(c, 40, 45);
    companionWrap <= 1'b0;
    run(8'h01, 8'h40, 40, 0, c);
    chk(c, 40, 45);
    // Pin clock, sync disable clear awake and sync disable set asleep
    for (int d = 0; d < 2; d++) begin
      sleepMode <= d[0];
      run({2'b10, 3'b000, d[0], 2'b01}, 8'h00, 10, 25, c);
      chk(c, 24, 26);
    end
    sleepMode <= 1'b0;
    // Wrap, sticky flag, mask and clear
    apb(1'b1, `GTM_OFF_CNTL, 32'hFF);
    apb(1'b1, `GTM_OFF_CNTH, 32'hFF);
    apb(1'b1, `GTM_OFF_CTRL, 32'h1);
    repeat (6) @(posedge mclk);
    apb(1'b1, `GTM_OFF_CTRL, 32'h0);
    apb(1'b0, `GTM_OFF_STAT, 32'h0);
    chk(rd[0], 1, 1);
    chk(irq, 0, 0);
    apb(1'b0, `GTM_OFF_CNTH, 32'h0);
    chk(rd[7:0], 0, 0);
    apb(1'b1, `GTM_OFF_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 1, 1);
    apb(1'b1, `GTM_OFF_STAT, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 0, 0);
    apb(1'b0, `GTM_OFF_STAT, 32'h0);
    chk(rd[0], 0, 0);
    // Crystal oscillator enable, Sleep and readiness
    apb(1'b1, `GTM_OFF_CTRL, 32'h08);
    apb(1'b0, `GTM_OFF_OSC, 32'h0);
    chk(rd[7], 0, 0);
    chk(crystalOscEnable, 1, 1);
    sleepMode <= 1'b1;
    repeat (30) @(posedge mclk);
    chk(crystalOscEnable, 1, 1);
    apb(1'b0, `GTM_OFF_OSC, 32'h0);
    chk(rd[7], 1, 1);
    // Crystal counting with sync disable set while asleep
    run(8'hCD, 8'h00, 90, 0, c);
    chk(c, 9, 11);
    sleepMode <= 1'b0;
    testDone();
  end
endmodule
`default_nettype wire
